// file: common/rpd_pkg.sv
// shared constants and types for the row packet command decoder
package rpd_pkg;

  // link framing: one row packet is eight link ticks of three row pins
  localparam int RPD_PINS = 3;
  localparam int RPD_TICKS = 8;
  localparam int RPD_PKT_W = 24;
  localparam logic [2:0] RPD_LAST_TICK = 3'h7;

  // field positions inside the assembled packet, first tick in the top bits
  localparam int RPD_DEV_T_POS = 23;
  localparam int RPD_DEV_F_POS = 22;
  localparam int RPD_DEV_LO_MSB = 21;
  localparam int RPD_DEV_LO_LSB = 18;
  localparam int RPD_AV_POS = 17;
  localparam int RPD_BANK_MSB = 16;
  localparam int RPD_BANK_LSB = 12;
  localparam int RPD_ROW_MSB = 8;
  localparam int RPD_OP_MSB = 10;

  // opcode encodings
  localparam logic [2:0] RPD_OP_LOW_NONE = 3'h0;
  localparam logic [2:0] RPD_OP_LOW_TEMP_CAL_CMD = 3'h1;
  localparam logic [2:0] RPD_OP_LOW_TEMP_CAL_ENABLE_CMD = 3'h2;
  localparam logic [4:0] RPD_OP_CLOSE_HI = 5'h18;
  localparam logic [6:0] RPD_OP_REF_OPEN_HI = 7'h0C;
  localparam logic [6:0] RPD_OP_REF_CLOSE_HI = 7'h54;
  localparam logic [4:0] RPD_OP_DEEP_MID = 5'h01;
  localparam logic [4:0] RPD_OP_LIGHT_MID = 5'h02;
  localparam logic [4:0] RPD_OP_LIGHT_IF_MID = 5'h03;
  localparam logic [6:0] RPD_OP_TEMP_CAL_CMD_HI = 7'h00;
  localparam logic [10:0] RPD_OP_IDLE = 11'h000;
  localparam logic [4:0] RPD_BANK_LAST = 5'h1F;

  // register map, byte addresses
  localparam logic [7:0] RPD_CTRL_OFS = 8'h00;
  localparam logic [7:0] RPD_STAT_OFS = 8'h04;
  localparam int RPD_CTRL_ID_MSB = 4;
  localparam int RPD_CTRL_LSA_POS = 8;
  localparam int RPD_STAT_CNT_LSB = 8;
  localparam logic [4:0] RPD_ID_RST = 5'h00;
  localparam logic [8:0] RPD_REF_RST = 9'h000;

  // power states, gray along active, standby, light sleep, deep sleep
  typedef enum logic [1:0] {
    RPD_PWR_ACTIVE = 2'h0,
    RPD_PWR_STANDBY = 2'h1,
    RPD_PWR_LIGHT = 2'h3,
    RPD_PWR_DEEP = 2'h2
  } rpd_pwr_t;

endpackage

// file: design/rpd_row_decoder.sv
// row packet command decoder: link sampler, deserialiser, decode, registers
//
// Functional notes
// - the two framing bits both frame the packet and carry the device msb.
// - framing bits both zero means no packet, no hit, no command.
// - framing bits both one is broadcast, every device hits.
// - one framing bit set: hit only when id equals the true bit and low bits.
// - commands execute only with device hit; otherwise the packet is ignored.
// - activate bit set opens the addressed row and enters full active.
// - activate bit clear makes an operation packet with eleven bit opcode.
// - opcode 11000 in bits 10..6 with low 000 closes the bank.
// - refresh open opens the row held in the refresh counter.
// - refresh open advances the counter only when the bank is all ones.
// - refresh close pulses bank close as bank close does, and also pulses refresh close.
// - bits 8..4 at 00001 with low 000 enter deep sleep.
// - 00010 enters light sleep, 00011 enters it only if allowed.
// - with low 000, bit 3 zero asks full active, one asks standby.
// - broadcast full active request never wakes a relaxed device.
// - bits 10..4 zero with low 001 or 010 give temperature calibrations.
// - opcode all zero is idle and does nothing.
// - groups marked free in each other's codes combine in one packet.
// - both packets carry five device and five bank bits, then row or opcode.
// - reserved bank and row positions are ignored.
`timescale 1ns/100ps

module rpd_row_decoder
  import rpd_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire logic link_clk_in,
  input wire logic [2:0] row_pins_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  output logic device_hit_out,
  output logic row_open_out,
  output logic refresh_open_out,
  output logic bank_close_out,
  output logic refresh_close_out,
  output logic temp_cal_out,
  output logic temp_cal_enable_out,
  output logic [4:0] bank_out,
  output logic [8:0] row_out,
  output logic [8:0] refresh_row_out,
  output logic [1:0] power_state_out
);

  logic lclk_s1_r;
  logic lclk_s2_r;
  logic lclk_prev_r;
  logic [2:0] pins_s1_r;
  logic [2:0] pins_s2_r;
  logic link_edge;
  logic in_pkt_r;
  logic [2:0] tick_r;
  logic [RPD_PKT_W-1:0] pkt_r;
  logic pkt_done_r;
  logic [4:0] own_device_id_r;
  logic light_allow_r;
  logic [8:0] refresh_row_counter_r;
  rpd_pwr_t pwr_r;
  rpd_pwr_t pwr_nxt;

  // packet fields
  logic dev_msb_true_bit;
  logic dev_msb_false_bit;
  logic [3:0] row_dev_low_bits;
  logic activate_select_bit;
  logic [4:0] row_bank_field;
  logic [8:0] row_addr_field;
  logic [10:0] row_opcode;
  logic broadcast;
  logic device_hit;
  logic low_none;
  logic op_pkt;
  logic close_cmd;
  logic ref_open_cmd;
  logic ref_close_cmd;
  logic deep_sleep_cmd;
  logic light_sleep_cmd;
  logic light_sleep_if_cmd;
  logic relax_row_cmd;
  logic active_req;
  logic idle_op;
  logic temp_cal_cmd_cmd;
  logic temp_cal_enable_cmd_cmd;

  // two-flop synchronisers for the link clock and the row pins
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      lclk_s1_r <= 1'b0;
      lclk_s2_r <= 1'b0;
      lclk_prev_r <= 1'b0;
      pins_s1_r <= 3'h0;
      pins_s2_r <= 3'h0;
    end else begin
      lclk_s1_r <= link_clk_in;
      lclk_s2_r <= lclk_s1_r;
      lclk_prev_r <= lclk_s2_r;
      pins_s1_r <= row_pins_in;
      pins_s2_r <= pins_s1_r;
    end
  end

  // rising edge of the synchronised link clock marks one link tick
  assign link_edge = lclk_s2_r & ~lclk_prev_r;

  // deserialiser: a nonzero framing pair on an idle tick starts a packet
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      in_pkt_r <= 1'b0;
      tick_r <= 3'h0;
      pkt_r <= 24'h000000;
      pkt_done_r <= 1'b0;
    end else begin
      pkt_done_r <= 1'b0;
      if (link_edge) begin
        if (!in_pkt_r) begin
          if (pins_s2_r[2] | pins_s2_r[1]) begin
            in_pkt_r <= 1'b1;
            tick_r <= 3'h1;
            pkt_r <= {pkt_r[RPD_PKT_W-RPD_PINS-1:0], pins_s2_r};
          end
        end else begin
          pkt_r <= {pkt_r[RPD_PKT_W-RPD_PINS-1:0], pins_s2_r};
          tick_r <= tick_r + 3'h1;
          if (tick_r == RPD_LAST_TICK) begin
            in_pkt_r <= 1'b0;
            pkt_done_r <= 1'b1;
          end
        end
      end
    end
  end

  // field split; reserved bank and row positions are simply not read
  assign dev_msb_true_bit = pkt_r[RPD_DEV_T_POS];
  assign dev_msb_false_bit = pkt_r[RPD_DEV_F_POS];
  assign row_dev_low_bits = pkt_r[RPD_DEV_LO_MSB:RPD_DEV_LO_LSB];
  assign activate_select_bit = pkt_r[RPD_AV_POS];
  assign row_bank_field = pkt_r[RPD_BANK_MSB:RPD_BANK_LSB];
  assign row_addr_field = pkt_r[RPD_ROW_MSB:0];
  assign row_opcode = pkt_r[RPD_OP_MSB:0];

  // device selection from the merged framing and device bits
  assign broadcast = dev_msb_true_bit & dev_msb_false_bit;
  assign device_hit = pkt_done_r & (broadcast
    | (dev_msb_true_bit & ~dev_msb_false_bit
       & (own_device_id_r == {1'b1, row_dev_low_bits}))
    | (~dev_msb_true_bit & dev_msb_false_bit
       & (own_device_id_r == {1'b0, row_dev_low_bits})));

  // opcode groups decode independently so they combine in one packet
  assign op_pkt = device_hit & ~activate_select_bit;
  assign low_none = row_opcode[2:0] == RPD_OP_LOW_NONE;
  assign idle_op = row_opcode == RPD_OP_IDLE;
  assign close_cmd = op_pkt & low_none & (row_opcode[10:6] == RPD_OP_CLOSE_HI);
  assign ref_open_cmd = op_pkt & low_none
    & (row_opcode[10:4] == RPD_OP_REF_OPEN_HI);
  assign ref_close_cmd = op_pkt & low_none
    & (row_opcode[10:4] == RPD_OP_REF_CLOSE_HI);
  assign deep_sleep_cmd = op_pkt & low_none & (row_opcode[8:4] == RPD_OP_DEEP_MID);
  assign light_sleep_cmd = op_pkt & low_none & (row_opcode[8:4] == RPD_OP_LIGHT_MID);
  assign light_sleep_if_cmd = op_pkt & low_none
    & (row_opcode[8:4] == RPD_OP_LIGHT_IF_MID);
  assign relax_row_cmd = op_pkt & low_none & row_opcode[3];
  assign active_req = op_pkt & low_none & ~row_opcode[3] & ~idle_op;
  assign temp_cal_cmd_cmd = op_pkt & (row_opcode[10:4] == RPD_OP_TEMP_CAL_CMD_HI)
    & (row_opcode[2:0] == RPD_OP_LOW_TEMP_CAL_CMD);
  assign temp_cal_enable_cmd_cmd = op_pkt & (row_opcode[10:4] == RPD_OP_TEMP_CAL_CMD_HI)
    & (row_opcode[2:0] == RPD_OP_LOW_TEMP_CAL_ENABLE_CMD);

  // command pulses and addresses, one cycle after the packet completes
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      device_hit_out <= 1'b0;
      row_open_out <= 1'b0;
      refresh_open_out <= 1'b0;
      bank_close_out <= 1'b0;
      refresh_close_out <= 1'b0;
      temp_cal_out <= 1'b0;
      temp_cal_enable_out <= 1'b0;
      bank_out <= 5'h00;
      row_out <= 9'h000;
    end else begin
      device_hit_out <= device_hit;
      row_open_out <= device_hit & activate_select_bit;
      refresh_open_out <= ref_open_cmd;
      bank_close_out <= close_cmd | ref_close_cmd;
      refresh_close_out <= ref_close_cmd;
      temp_cal_out <= temp_cal_cmd_cmd;
      temp_cal_enable_out <= temp_cal_enable_cmd_cmd;
      if (device_hit) begin
        bank_out <= row_bank_field;
        row_out <= activate_select_bit ? row_addr_field : refresh_row_counter_r;
      end
    end
  end

  // refresh row counter, one step per sweep through the banks
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      refresh_row_counter_r <= RPD_REF_RST;
    end else if (ref_open_cmd && row_bank_field == RPD_BANK_LAST) begin
      refresh_row_counter_r <= refresh_row_counter_r + 9'h001;
    end
  end

  // power state next value; sleep wins over standby, standby over active
  always_comb begin
    pwr_nxt = pwr_r;
    if (device_hit && activate_select_bit) begin
      pwr_nxt = RPD_PWR_ACTIVE;
    end else if (deep_sleep_cmd) begin
      pwr_nxt = RPD_PWR_DEEP;
    end else if (light_sleep_cmd || (light_sleep_if_cmd && light_allow_r)) begin
      pwr_nxt = RPD_PWR_LIGHT;
    end else if (relax_row_cmd) begin
      pwr_nxt = RPD_PWR_STANDBY;
    end else if (active_req) begin
      case (pwr_r)
        RPD_PWR_STANDBY: begin
          if (!broadcast) begin
            pwr_nxt = RPD_PWR_ACTIVE;
          end
        end
        default: begin
          pwr_nxt = RPD_PWR_ACTIVE;
        end
      endcase
    end
  end

  // power state register
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      pwr_r <= RPD_PWR_ACTIVE;
    end else begin
      pwr_r <= pwr_nxt;
    end
  end

  // control register writes
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      own_device_id_r <= RPD_ID_RST;
      light_allow_r <= 1'b0;
    end else if (reg_wr_in && reg_addr_in == RPD_CTRL_OFS) begin
      own_device_id_r <= reg_wdata_in[RPD_CTRL_ID_MSB:0];
      light_allow_r <= reg_wdata_in[RPD_CTRL_LSA_POS];
    end
  end

  // read data one cycle after the read strobe, zero otherwise
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      reg_rdata_out <= 32'h00000000;
    end else if (reg_rd_in && reg_addr_in == RPD_CTRL_OFS) begin
      reg_rdata_out <= {23'h000000, light_allow_r, 3'h0, own_device_id_r};
    end else if (reg_rd_in && reg_addr_in == RPD_STAT_OFS) begin
      reg_rdata_out <= {15'h0000, refresh_row_counter_r, 6'h00, pwr_r};
    end else begin
      reg_rdata_out <= 32'h00000000;
    end
  end

  assign refresh_row_out = refresh_row_counter_r;
  assign power_state_out = pwr_r;

  // helper for the broadcast wake check
  logic bcast_wake_try;
  assign bcast_wake_try = active_req & broadcast & (pwr_r == RPD_PWR_STANDBY)
    & ~deep_sleep_cmd & ~light_sleep_cmd & ~light_sleep_if_cmd & ~relax_row_cmd;

  // checks
  chk_no_frame_hit: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    pkt_done_r && !dev_msb_true_bit && !dev_msb_false_bit |=> !device_hit_out)
    else $error("empty frame produced a hit");

  // an idle tick with both framing bits low must not open a packet
  chk_empty_slot: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    link_edge && !in_pkt_r && pins_s2_r[2:1] == 2'b00 |=> !in_pkt_r && !pkt_done_r)
    else $error("empty slot started a packet");

  chk_bcast_hit_all: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    pkt_done_r && broadcast |=> device_hit_out)
    else $error("broadcast packet missed");

  chk_single_dev_match: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    pkt_done_r && (dev_msb_true_bit ^ dev_msb_false_bit)
    |=> device_hit_out == ($past(own_device_id_r) == {$past(dev_msb_true_bit),
                                                      $past(row_dev_low_bits)}))
    else $error("single device match wrong");

  chk_miss_no_cmd: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    !device_hit_out |-> !(row_open_out || bank_close_out || refresh_open_out
                          || temp_cal_out || temp_cal_enable_out))
    else $error("command without device hit");

  chk_open_goes_active: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    row_open_out |-> power_state_out == RPD_PWR_ACTIVE)
    else $error("row open did not enter full active");

  chk_close_decode: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    device_hit && !activate_select_bit && row_opcode[10:6] == RPD_OP_CLOSE_HI
    && row_opcode[2:0] == RPD_OP_LOW_NONE |=> bank_close_out ##1 !bank_close_out)
    else $error("bank close not one pulse");

  chk_refresh_advance: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    refresh_open_out |-> refresh_row_out == ($past(refresh_row_out)
      + ((bank_out == RPD_BANK_LAST) ? 9'h001 : 9'h000)))
    else $error("refresh counter step wrong");

  // refresh open takes its row from the counter, not from the packet
  chk_refresh_row_src: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    ref_open_cmd |=> refresh_open_out && row_out == $past(refresh_row_counter_r))
    else $error("refresh open row not taken from counter");

  // a packet that misses leaves counter and power state alone
  chk_miss_keeps_state: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    pkt_done_r && !device_hit |=> $stable(refresh_row_out) && $stable(power_state_out))
    else $error("missed packet changed state");

  // close and conditional light sleep both act from one packet
  chk_combined_groups: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    close_cmd && light_sleep_if_cmd && light_allow_r
    |=> bank_close_out && power_state_out == RPD_PWR_LIGHT)
    else $error("combined opcode groups did not all act");

  chk_bcast_no_wake: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    bcast_wake_try |=> power_state_out == RPD_PWR_STANDBY)
    else $error("broadcast woke a relaxed device");

  chk_idle_nothing: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    op_pkt && idle_op |=> !bank_close_out && $stable(power_state_out))
    else $error("idle opcode acted");

  cov_broadcast: cover property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    pkt_done_r && broadcast);
  cov_refresh_wrap: cover property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    refresh_open_out && bank_out == RPD_BANK_LAST);
  cov_row_open: cover property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    row_open_out);
  cov_combined: cover property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    bank_close_out && power_state_out == RPD_PWR_LIGHT);

endmodule // rpd_row_decoder

// file: verif/rpd_ctrl_model.sv
// controller model that drives the link clock and the row pins
`timescale 1ns/100ps

module rpd_ctrl_model (
  output logic link_clk_out,
  output logic [2:0] row_pins_out
);
  // link clock stands still low between packets
  initial begin
    link_clk_out = 1'b0;
    row_pins_out = 3'h0;
  end

  // eight ticks, first tick carries framing bits and the top device bit
  task automatic send_pkt(input logic [23:0] pkt);
    #13;
    for (int i = 0; i < 8; i++) begin
      row_pins_out = pkt[23 - 3 * i -: 3];
      #400 link_clk_out = 1'b1;
      #400 link_clk_out = 1'b0;
    end
    row_pins_out = ~pkt[2:0]; // stale value inverted once the frame is over
  endtask
endmodule // rpd_ctrl_model

// file: verif/tb_top.sv
// self-checking bench for the row packet command decoder
`timescale 1ns/100ps

module tb_top;
  import rpd_pkg::*;
  localparam logic [6:0] P_HIT = 7'h40;
  localparam logic [6:0] P_OPEN = 7'h20;
  localparam logic [6:0] P_ROPEN = 7'h10;
  localparam logic [6:0] P_CLOSE = 7'h08;
  localparam logic [6:0] P_RCLOSE = 7'h04;
  localparam logic [6:0] P_TEMP_CAL_CMD = 7'h02;
  localparam logic [6:0] P_TEMP_CAL_ENABLE_CMD = 7'h01;
  logic ref_clk, reset_n, link_clk, reg_wr, reg_rd;
  logic [2:0] row_pins;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rdv;
  logic device_hit, row_open, refresh_open, bank_close, refresh_close, temp_cal, temp_cal_en;
  logic [4:0] bank;
  logic [8:0] row, refresh_row;
  logic [1:0] power_state;
  logic [6:0] pulses;
  int errors = 0;
  int samples_checked = 0;

  assign pulses = {device_hit, row_open, refresh_open, bank_close, refresh_close, temp_cal,
                   temp_cal_en};

  rpd_ctrl_model rpd_ctrl_model_inst (.link_clk_out(link_clk), .row_pins_out(row_pins));

  rpd_row_decoder rpd_row_decoder_inst (
    .ref_clk_in(ref_clk), .reset_n_in(reset_n), .link_clk_in(link_clk),
    .row_pins_in(row_pins), .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
    .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata),
    .device_hit_out(device_hit), .row_open_out(row_open), .refresh_open_out(refresh_open),
    .bank_close_out(bank_close), .refresh_close_out(refresh_close), .temp_cal_out(temp_cal),
    .temp_cal_enable_out(temp_cal_en), .bank_out(bank), .row_out(row),
    .refresh_row_out(refresh_row), .power_state_out(power_state)
  );

  // 10 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic end_sim;
    if (errors == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    d = reg_rdata;
    @(negedge ref_clk);
    cmp("rdata_after", 32'h0, reg_rdata);
  endtask

  function automatic logic [23:0] mk(input logic [1:0] fr, input logic [3:0] lo,
                                     input logic av, input logic [4:0] bk,
                                     input logic [11:0] tail);
    return {fr, lo, av, bk, tail};
  endfunction

  // send one packet while gathering every one-cycle pulse, then judge pulses and power
  task automatic pk(input logic [23:0] p, input logic [6:0] ep, input logic [1:0] epw);
    logic [6:0] seen;
    seen = 7'h00;
    fork
      rpd_ctrl_model_inst.send_pkt(p);
      repeat (68) begin
        @(negedge ref_clk);
        seen = seen | pulses;
      end
    join
    cmp("pulses", {25'h0, ep}, {25'h0, seen});
    cmp("power", {30'h0, epw}, {30'h0, power_state});
  endtask

  function automatic logic [23:0] op(input logic [4:0] bk, input logic [10:0] o);
    return mk(2'b10, 4'h5, 1'b0, bk, {1'b0, o});
  endfunction

  task automatic t_reset_regs;
    rd(RPD_CTRL_OFS, rdv);
    cmp("ctrl_rst", 32'h0, rdv);
    rd(RPD_STAT_OFS, rdv);
    cmp("stat_rst", 32'h0, rdv);
    cmp("refresh_rst", 32'h0, {23'h0, refresh_row});
    wr(RPD_CTRL_OFS, 32'h0000_0015);
    wr(RPD_STAT_OFS, 32'hFFFF_FFFF);
    wr(8'h08, 32'hFFFF_FFFF);
    rd(RPD_CTRL_OFS, rdv);
    cmp("ctrl", 32'h0000_0015, rdv);
    rd(RPD_STAT_OFS, rdv);
    cmp("stat_ro", 32'h0, rdv);
    rd(8'h08, rdv);
    cmp("unmapped", 32'h0, rdv);
  endtask

  task automatic t_select;
    pk(mk(2'b00, 4'h9, 1'b0, 5'h09, 12'h249), 7'h00, RPD_PWR_ACTIVE);
    pk(mk(2'b11, 4'h0, 1'b1, 5'h04, 12'h002), P_HIT | P_OPEN, RPD_PWR_ACTIVE);
    pk(mk(2'b10, 4'h5, 1'b1, 5'h09, 12'hE5A), P_HIT | P_OPEN, RPD_PWR_ACTIVE);
    cmp("row", 32'h05A, {23'h0, row});
    cmp("bank", 32'h09, {27'h0, bank});
    pk(mk(2'b01, 4'h5, 1'b1, 5'h11, 12'h003), 7'h00, RPD_PWR_ACTIVE);
    pk(mk(2'b10, 4'h4, 1'b1, 5'h12, 12'h004), 7'h00, RPD_PWR_ACTIVE);
    cmp("bank_miss", 32'h09, {27'h0, bank});
  endtask

  task automatic t_ops;
    pk(op(5'h03, 11'h600), P_HIT | P_CLOSE, RPD_PWR_ACTIVE);
    pk(op(5'h03, 11'h540), P_HIT | P_CLOSE | P_RCLOSE, RPD_PWR_ACTIVE);
    pk(op(5'h1E, 11'h0C0), P_HIT | P_ROPEN, RPD_PWR_ACTIVE);
    cmp("cnt_hold", 32'h0, {23'h0, refresh_row});
    pk(op(5'h1F, 11'h0C0), P_HIT | P_ROPEN, RPD_PWR_ACTIVE);
    cmp("cnt_inc", 32'h1, {23'h0, refresh_row});
    pk(mk(2'b01, 4'h5, 1'b0, 5'h1F, 12'h0C0), 7'h00, RPD_PWR_ACTIVE);
    cmp("cnt_miss", 32'h1, {23'h0, refresh_row});
    pk(mk(2'b11, 4'h0, 1'b0, 5'h1F, 12'h0C0), P_HIT | P_ROPEN, RPD_PWR_ACTIVE);
    cmp("ref_row", 32'h1, {23'h0, row});
    rd(RPD_STAT_OFS, rdv);
    cmp("stat_cnt", 32'h0000_0200, rdv);
    pk(op(5'h00, 11'h001), P_HIT | P_TEMP_CAL_CMD, RPD_PWR_ACTIVE);
    pk(op(5'h00, 11'h002), P_HIT | P_TEMP_CAL_ENABLE_CMD, RPD_PWR_ACTIVE);
  endtask

  task automatic t_power;
    pk(op(5'h00, 11'h008), P_HIT, RPD_PWR_STANDBY);
    pk(mk(2'b11, 4'h0, 1'b0, 5'h00, 12'h040), P_HIT, RPD_PWR_STANDBY);
    pk(op(5'h00, 11'h040), P_HIT, RPD_PWR_ACTIVE);
    pk(op(5'h00, 11'h010), P_HIT, RPD_PWR_DEEP);
    pk(op(5'h00, 11'h040), P_HIT, RPD_PWR_ACTIVE);
    pk(op(5'h00, 11'h020), P_HIT, RPD_PWR_LIGHT);
    pk(op(5'h00, 11'h000), P_HIT, RPD_PWR_LIGHT);
    pk(op(5'h00, 11'h040), P_HIT, RPD_PWR_ACTIVE);
    pk(op(5'h00, 11'h030), P_HIT, RPD_PWR_ACTIVE);
    wr(RPD_CTRL_OFS, 32'h0000_0115);
    pk(op(5'h06, 11'h638), P_HIT | P_CLOSE, RPD_PWR_LIGHT);
    rd(RPD_STAT_OFS, rdv);
    cmp("stat_pwr", 32'h0000_0203, rdv);
    pk(op(5'h00, 11'h018), P_HIT, RPD_PWR_DEEP);
  endtask

  // main sequence: reset for three cycles, then the scenarios
  initial begin
    reset_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'b1;
    t_reset_regs();
    t_select();
    t_ops();
    t_power();
    end_sim();
  end

  // watchdog well beyond the expected run of about 170 us
  initial begin
    #2000000;
    errors++;
    end_sim();
  end
endmodule // tb_top
